// *** sxdec_pkg.sv ***
/*
 * constants and types for the stack and exchange opcode decoder:
 * opcode patterns, field codes, execution clock counts, decoded forms.
 * assumes nothing beyond a systemverilog compiler.
 */
package sxdec_pkg;

    // full opcode bytes
    localparam logic [7:0] SXD_OPC_PUSH_MEM = 8'hFF;
    localparam logic [7:0] SXD_OPC_POP_MEM = 8'h8F;
    localparam logic [7:0] SXD_OPC_PUSH_ALL = 8'h60;
    localparam logic [7:0] SXD_OPC_POP_ALL = 8'h61;

    // upper- and lower-bit patterns of forms not fixed by a full opcode byte
    localparam logic [4:0] SXD_HI_PUSH_REG = 5'h0A;
    localparam logic [4:0] SXD_HI_POP_REG = 5'h0B;
    localparam logic [4:0] SXD_HI_EXCH_ACC = 5'h12;
    localparam logic [6:0] SXD_HI_EXCH_RM = 7'h43;
    localparam logic [5:0] SXD_HI_PUSH_IMM = 6'h1A;
    localparam logic [2:0] SXD_HI_SEG = 3'h0;
    localparam logic [2:0] SXD_LO_PUSH_SEG = 3'h6;
    localparam logic [2:0] SXD_LO_POP_SEG = 3'h7;

    // modrm field codes and the code segment register code
    localparam logic [2:0] SXD_REG_PUSH_MEM = 3'h6;
    localparam logic [2:0] SXD_REG_POP_MEM = 3'h0;
    localparam logic [1:0] SXD_SEG_CODE = 2'h1;
    localparam logic [1:0] SXD_MOD_REGISTER = 2'h3;
    localparam logic [1:0] SXD_MOD_DISP8 = 2'h1;
    localparam logic [1:0] SXD_MOD_DISP16 = 2'h2;
    localparam logic [1:0] SXD_MOD_NODISP = 2'h0;
    localparam logic [2:0] SXD_RM_DIRECT = 3'h6;

    // execution clock counts
    localparam logic [5:0] SXD_CYC_PUSH_MEM = 6'h10;
    localparam logic [5:0] SXD_CYC_PUSH_REG = 6'h0A;
    localparam logic [5:0] SXD_CYC_PUSH_SEG = 6'h09;
    localparam logic [5:0] SXD_CYC_PUSH_IMM = 6'h0A;
    localparam logic [5:0] SXD_CYC_PUSH_ALL = 6'h24;
    localparam logic [5:0] SXD_CYC_POP_MEM = 6'h14;
    localparam logic [5:0] SXD_CYC_POP_REG = 6'h0A;
    localparam logic [5:0] SXD_CYC_POP_SEG = 6'h08;
    localparam logic [5:0] SXD_CYC_POP_ALL = 6'h33;
    localparam logic [5:0] SXD_CYC_EXCH_REG = 6'h04;
    localparam logic [5:0] SXD_CYC_EXCH_MEM = 6'h11;
    localparam logic [5:0] SXD_CYC_EXCH_ACC = 6'h03;

    // general register count for the all-register forms
    localparam logic [3:0] SXD_NUM_GPR = 4'h8;

    typedef enum logic [3:0] {
        SXD_NONE, SXD_PUSH_MEM, SXD_PUSH_REG, SXD_PUSH_SEG, SXD_PUSH_IMM, SXD_PUSH_ALL,
        SXD_POP_MEM, SXD_POP_REG, SXD_POP_SEG, SXD_POP_ALL, SXD_EXCH_RM, SXD_EXCH_ACC
    } sxdec_op_e;

    typedef enum logic [2:0] {
        ST_OPCODE, ST_MODRM, ST_DISP, ST_IMM, ST_EXEC
    } sxdec_state_e;

endpackage

// *** sxdec_cycle_timer.sv ***
/*
 * execution clock timer: loads a clock count and flags its last clock.
 * assumes load is a one-cycle pulse from the decoder on the same clock.
 */
`timescale 1ns/1ps
module sxdec_cycle_timer
    import sxdec_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [5:0] count,
    output logic running,
    output logic last
);
    logic [5:0] cnt_reg;

    // count down one per clock after a load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != 6'h00) begin
            cnt_reg <= cnt_reg - 6'h01;
        end
    end

    assign running = (cnt_reg != 6'h00);
    assign last = (cnt_reg == 6'h01);
endmodule // sxdec_cycle_timer

// *** sxdec_decoder.sv ***
/*
 * stack and exchange opcode decoder: takes instruction bytes, decodes
 * push, pop, push-all, pop-all and exchange forms, collects modrm,
 * displacement and immediate bytes, then holds busy for the clock count.
 * assumes the fetch path offers one byte per cycle under valid/ready
 * and that the bus unit reads the decoded fields while busy is high.
 */
// Behaviour
// [RL1] 0xFF with modrm reg 110 pushes a memory operand, 16 clocks.
// [RL2] 01010 reg pushes a general register, 10 clocks.
// [RL3] 000 reg 110 pushes a segment register, 9 clocks.
// [RL4] 011010 s0 pushes immediate; second byte only when s is zero, else sign-extend.
// [RL5] 0x60 pushes all eight general registers in sequence, 36 clocks.
// [RL6] 0x8F with modrm reg 000 pops into memory, 20 clocks.
// [RL7] 01011 reg pops into a general register, 10 clocks.
// [RL8] 000 reg 111 pops a segment register in 8 clocks; reg 01 excluded.
// [RL9] 0x61 restores all eight general registers, 51 clocks.
// [RL10] 1000011 w plus modrm swaps operands: 4 clocks register, 17 memory.
// [RL11] 10010 reg swaps accumulator with a register, 3 clocks.
// [RL12] width bit zero means byte operation, one means word operation.
`timescale 1ns/1ps
module sxdec_decoder
    import sxdec_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready,
    output logic busy,
    output logic done,
    output logic unsupported,
    output sxdec_op_e op_kind,
    output logic word_op,
    output logic mem_operand,
    output logic [2:0] reg_field,
    output logic [1:0] seg_field,
    output logic [1:0] mod_field,
    output logic [2:0] rm_field,
    output logic [15:0] imm_data,
    output logic seq_active,
    output logic [2:0] seq_reg
);
    sxdec_state_e state_reg, state_next;
    sxdec_op_e op_reg, dec_op, launch_op;
    logic [7:0] opc_reg;
    logic dec_modrm;
    logic take;
    logic byte_ready_reg, busy_reg, done_reg, unsup_reg;
    logic word_reg, mem_reg;
    logic [2:0] reg_reg, rm_reg;
    logic [1:0] seg_reg, mod_reg;
    logic [15:0] imm_reg;
    logic [1:0] left_reg;
    logic [1:0] disp_need;
    logic modrm_bad;
    logic load;
    logic [5:0] cyc_sel;
    logic t_last, launch_mem;
    logic seq_act_reg;
    logic [2:0] seq_reg_reg;
    logic [3:0] seq_cnt_reg;
    logic [5:0] busy_cnt_reg;

    assign take = byte_valid && byte_ready_reg;

    // opcode byte decode
    always_comb begin
        dec_op = SXD_NONE;
        dec_modrm = 1'b0;
        if (byte_data == SXD_OPC_PUSH_MEM) begin
            dec_op = SXD_PUSH_MEM; // RL1
            dec_modrm = 1'b1;
        end else if (byte_data == SXD_OPC_POP_MEM) begin
            dec_op = SXD_POP_MEM; // RL6
            dec_modrm = 1'b1;
        end else if (byte_data[7:1] == SXD_HI_EXCH_RM) begin
            dec_op = SXD_EXCH_RM; // RL10
            dec_modrm = 1'b1;
        end else if (byte_data[7:3] == SXD_HI_PUSH_REG) begin
            dec_op = SXD_PUSH_REG; // RL2
        end else if (byte_data[7:3] == SXD_HI_POP_REG) begin
            dec_op = SXD_POP_REG; // RL7
        end else if (byte_data[7:3] == SXD_HI_EXCH_ACC) begin
            dec_op = SXD_EXCH_ACC; // RL11
        end else if (byte_data[7:5] == SXD_HI_SEG && byte_data[2:0] == SXD_LO_PUSH_SEG) begin
            dec_op = SXD_PUSH_SEG; // RL3
        end else if (byte_data[7:5] == SXD_HI_SEG && byte_data[2:0] == SXD_LO_POP_SEG
                     && byte_data[4:3] != SXD_SEG_CODE) begin
            dec_op = SXD_POP_SEG; // RL8
        end else if (byte_data == SXD_OPC_PUSH_ALL) begin
            dec_op = SXD_PUSH_ALL; // RL5
        end else if (byte_data == SXD_OPC_POP_ALL) begin
            dec_op = SXD_POP_ALL; // RL9
        end else if (byte_data[7:2] == SXD_HI_PUSH_IMM && !byte_data[0]) begin
            dec_op = SXD_PUSH_IMM; // RL4
        end
    end

    // modrm checks: reg field for the memory forms and displacement length
    always_comb begin
        modrm_bad = 1'b0;
        if (op_reg == SXD_PUSH_MEM && byte_data[5:3] != SXD_REG_PUSH_MEM) begin
            modrm_bad = 1'b1; // RL1
        end
        if (op_reg == SXD_POP_MEM && byte_data[5:3] != SXD_REG_POP_MEM) begin
            modrm_bad = 1'b1; // RL6
        end
        case (byte_data[7:6])
            SXD_MOD_DISP8: disp_need = 2'h1;
            SXD_MOD_DISP16: disp_need = 2'h2;
            SXD_MOD_NODISP: disp_need = (byte_data[2:0] == SXD_RM_DIRECT) ? 2'h2 : 2'h0;
            default: disp_need = 2'h0;
        endcase
    end

    // a one-byte form, or a modrm with no displacement, launches before op_reg and mem_reg load
    assign launch_op = (state_reg == ST_OPCODE) ? dec_op : op_reg;
    assign launch_mem = (state_reg == ST_MODRM) ? (byte_data[7:6] != SXD_MOD_REGISTER) : mem_reg;

    // clock count for the form now being launched
    always_comb begin
        case (launch_op)
            SXD_PUSH_MEM: cyc_sel = SXD_CYC_PUSH_MEM; // RL1
            SXD_PUSH_REG: cyc_sel = SXD_CYC_PUSH_REG; // RL2
            SXD_PUSH_SEG: cyc_sel = SXD_CYC_PUSH_SEG; // RL3
            SXD_PUSH_IMM: cyc_sel = SXD_CYC_PUSH_IMM; // RL4
            SXD_PUSH_ALL: cyc_sel = SXD_CYC_PUSH_ALL; // RL5
            SXD_POP_MEM: cyc_sel = SXD_CYC_POP_MEM; // RL6
            SXD_POP_REG: cyc_sel = SXD_CYC_POP_REG; // RL7
            SXD_POP_SEG: cyc_sel = SXD_CYC_POP_SEG; // RL8
            SXD_POP_ALL: cyc_sel = SXD_CYC_POP_ALL; // RL9
            SXD_EXCH_RM: cyc_sel = launch_mem ? SXD_CYC_EXCH_MEM : SXD_CYC_EXCH_REG; // RL10
            SXD_EXCH_ACC: cyc_sel = SXD_CYC_EXCH_ACC; // RL11
            default: cyc_sel = 6'h01;
        endcase
    end

    // next state: opcode, modrm, displacement, immediate, execute
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OPCODE: begin
                if (take && dec_op != SXD_NONE) begin
                    if (dec_modrm) begin
                        state_next = ST_MODRM;
                    end else if (dec_op == SXD_PUSH_IMM) begin
                        state_next = ST_IMM;
                    end else begin
                        state_next = ST_EXEC;
                    end
                end
            end
            ST_MODRM: begin
                if (take) begin
                    if (modrm_bad) begin
                        state_next = ST_OPCODE;
                    end else if (disp_need != 2'h0) begin
                        state_next = ST_DISP;
                    end else begin
                        state_next = ST_EXEC;
                    end
                end
            end
            ST_DISP: begin
                if (take && left_reg == 2'h1) begin
                    state_next = ST_EXEC;
                end
            end
            ST_IMM: begin
                if (take && left_reg == 2'h1) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (t_last) begin
                    state_next = ST_OPCODE;
                end
            end
            default: state_next = ST_OPCODE;
        endcase
    end

    // timer is loaded on the cycle the state enters execute
    assign load = (state_next == ST_EXEC) && (state_reg != ST_EXEC);

    sxdec_cycle_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .load(load),
        .count(cyc_sel),
        .running(),
        .last(t_last)
    );

    // state, handshake and status flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_OPCODE;
            byte_ready_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            unsup_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            byte_ready_reg <= (state_next != ST_EXEC);
            busy_reg <= (state_next == ST_EXEC);
            done_reg <= (state_reg == ST_EXEC) && t_last;
            unsup_reg <= take && ((state_reg == ST_OPCODE && dec_op == SXD_NONE)
                                  || (state_reg == ST_MODRM && modrm_bad)); // RL8
        end
    end

    // decoded opcode fields, captured with the opcode byte; the exchange reg field is taken again from modrm
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= SXD_NONE;
            opc_reg <= 8'h00;
            word_reg <= 1'b0;
            reg_reg <= 3'h0;
            seg_reg <= 2'h0;
        end else if (take && state_reg == ST_OPCODE) begin
            op_reg <= dec_op;
            opc_reg <= byte_data;
            reg_reg <= byte_data[2:0]; // RL2 RL7 RL11
            seg_reg <= byte_data[4:3]; // RL3 RL8
            if (dec_op == SXD_EXCH_RM) begin
                word_reg <= byte_data[0]; // RL12
            end else begin
                word_reg <= 1'b1; // stack and accumulator forms are word wide
            end
        end else if (take && state_reg == ST_MODRM && op_reg == SXD_EXCH_RM) begin
            reg_reg <= byte_data[5:3]; // RL10
        end
    end

    // modrm operand fields and byte counter for displacement or immediate
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mod_reg <= 2'h0;
            rm_reg <= 3'h0;
            mem_reg <= 1'b0;
            left_reg <= 2'h0;
        end else if (take && state_reg == ST_OPCODE) begin
            mem_reg <= (dec_op == SXD_PUSH_MEM) || (dec_op == SXD_POP_MEM);
            left_reg <= byte_data[1] ? 2'h1 : 2'h2; // RL4
        end else if (take && state_reg == ST_MODRM) begin
            mod_reg <= byte_data[7:6];
            rm_reg <= byte_data[2:0];
            mem_reg <= (byte_data[7:6] != SXD_MOD_REGISTER); // RL10
            left_reg <= disp_need;
        end else if (take && (state_reg == ST_DISP || state_reg == ST_IMM)) begin
            left_reg <= left_reg - 2'h1;
        end
    end

    // immediate assembly: low byte first, sign-extended when only one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            imm_reg <= 16'h0000;
        end else if (take && state_reg == ST_IMM) begin
            if (opc_reg[1]) begin
                imm_reg <= {{8{byte_data[7]}}, byte_data}; // RL4
            end else if (left_reg == 2'h2) begin
                imm_reg <= {8'h00, byte_data};
            end else begin
                imm_reg <= {byte_data, imm_reg[7:0]}; // RL4
            end
        end
    end

    // register walk for the all-register forms, one register per clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq_act_reg <= 1'b0;
            seq_reg_reg <= 3'h0;
            seq_cnt_reg <= 4'h0;
        end else if (load) begin
            seq_act_reg <= (launch_op == SXD_PUSH_ALL) || (launch_op == SXD_POP_ALL); // RL5 RL9
            seq_reg_reg <= (launch_op == SXD_POP_ALL) ? 3'h7 : 3'h0;
            seq_cnt_reg <= 4'h0;
        end else if (seq_act_reg) begin
            seq_cnt_reg <= seq_cnt_reg + 4'h1;
            seq_reg_reg <= (op_reg == SXD_POP_ALL) ? seq_reg_reg - 3'h1 : seq_reg_reg + 3'h1;
            if (seq_cnt_reg == SXD_NUM_GPR - 4'h1) begin
                seq_act_reg <= 1'b0;
            end
        end
    end

    // helper: clocks spent busy on the current operation
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= 6'h00;
        end else if (busy_reg) begin
            busy_cnt_reg <= busy_cnt_reg + 6'h01;
        end else if (done_reg) begin
            busy_cnt_reg <= 6'h00;
        end
    end

    assign byte_ready = byte_ready_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign unsupported = unsup_reg;
    assign op_kind = op_reg;
    assign word_op = word_reg;
    assign mem_operand = mem_reg;
    assign reg_field = reg_reg;
    assign seg_field = seg_reg;
    assign mod_field = mod_reg;
    assign rm_field = rm_reg;
    assign imm_data = imm_reg;
    assign seq_active = seq_act_reg;
    assign seq_reg = seq_reg_reg;

    // execution length, sign-extension, code segment refusal and width bit checks
    a_push_mem_time: assert property (@(posedge clock) disable iff (!rst_n) // RL1
        done_reg && op_reg == SXD_PUSH_MEM |-> busy_cnt_reg == 6'h10)
        else $error("push memory did not take 16 clocks");
    a_push_reg_time: assert property (@(posedge clock) disable iff (!rst_n) // RL2
        done_reg && op_reg == SXD_PUSH_REG |-> busy_cnt_reg == 6'h0A)
        else $error("push register did not take 10 clocks");
    a_push_seg_time: assert property (@(posedge clock) disable iff (!rst_n) // RL3
        $rose(busy_reg) && op_reg == SXD_PUSH_SEG |-> busy_reg [*8] ##1 busy_reg ##1 done_reg)
        else $error("push segment did not take 9 clocks");
    a_push_imm_sign: assert property (@(posedge clock) disable iff (!rst_n) // RL4
        $rose(busy_reg) && op_reg == SXD_PUSH_IMM && opc_reg[1] |-> imm_reg[15:8] == {8{imm_reg[7]}})
        else $error("short immediate not sign-extended");
    a_push_all_time: assert property (@(posedge clock) disable iff (!rst_n) // RL5
        done_reg && op_reg == SXD_PUSH_ALL |-> busy_cnt_reg == 6'h24 && !seq_act_reg)
        else $error("push all did not take 36 clocks");
    a_pop_mem_time: assert property (@(posedge clock) disable iff (!rst_n) // RL6
        done_reg && op_reg == SXD_POP_MEM |-> busy_cnt_reg == 6'h14)
        else $error("pop memory did not take 20 clocks");
    a_pop_reg_time: assert property (@(posedge clock) disable iff (!rst_n) // RL7
        done_reg && op_reg == SXD_POP_REG |-> busy_cnt_reg == 6'h0A)
        else $error("pop register did not take 10 clocks");
    a_pop_seg_code: assert property (@(posedge clock) disable iff (!rst_n) // RL8
        take && state_reg == ST_OPCODE && byte_data == 8'h0F |=> unsup_reg && !busy_reg)
        else $error("code segment pop was accepted");
    a_pop_all_time: assert property (@(posedge clock) disable iff (!rst_n) // RL9
        done_reg && op_reg == SXD_POP_ALL |-> busy_cnt_reg == 6'h33)
        else $error("pop all did not take 51 clocks");
    a_exch_rm_time: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        done_reg && op_reg == SXD_EXCH_RM |-> busy_cnt_reg == (mem_reg ? 6'h11 : 6'h04))
        else $error("exchange did not take 4 or 17 clocks");
    a_exch_acc_time: assert property (@(posedge clock) disable iff (!rst_n) // RL11
        $rose(busy_reg) && op_reg == SXD_EXCH_ACC |-> busy_reg [*3] ##1 done_reg)
        else $error("accumulator exchange did not take 3 clocks");
    a_width_bit: assert property (@(posedge clock) disable iff (!rst_n) // RL12
        busy_reg && op_reg == SXD_EXCH_RM |-> word_reg == opc_reg[0])
        else $error("width bit not honoured");
endmodule // sxdec_decoder

// *** sxdec_fetch_model.sv ***
/*
 * fetch path model: offers queued instruction bytes one at a time under
 * valid/ready, with an optional stall of gap idle cycles after each taken byte.
 * assumes byte_ready is a register of the decoder on the same rising clock.
 */
`timescale 1ns/1ps
module sxdec_fetch_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic byte_ready,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    logic [7:0] pending[$];
    int gap = 0;
    int wait_cnt;
    logic taken;

    // byte is held until taken; an idle data line toggles so stale bytes never look valid
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'hA5;
        wait_cnt = 0;
        forever begin
            @(posedge clock);
            taken = byte_valid && byte_ready;
            #1;
            if (taken) begin
                void'(pending.pop_front());
                wait_cnt = gap;
            end
            if (rst_n && pending.size() > 0 && wait_cnt == 0) begin
                byte_valid = 1'b1;
                byte_data = pending[0];
            end else begin
                if (wait_cnt > 0) wait_cnt--;
                byte_valid = 1'b0;
                byte_data = ~byte_data;
            end
        end
    end
endmodule // sxdec_fetch_model

// *** tb_top.sv ***
/*
 * self-checking bench for the stack and exchange opcode decoder: feeds each
 * form through the fetch model, times busy, checks done and decoded fields.
 * assumes the decoder and package as delivered and the fetch model beside it.
 */
`timescale 1ns/1ps
module tb_top;
    import sxdec_pkg::*;
    logic clock, rst_n, byte_valid, byte_ready, busy, done, unsupported;
    logic word_op, mem_operand, seq_active;
    logic [7:0] byte_data;
    logic [2:0] reg_field, rm_field, seq_reg;
    logic [1:0] seg_field, mod_field;
    logic [15:0] imm_data;
    sxdec_op_e op_kind;
    int miscompares = 0;
    int num_checks = 0;

    sxdec_decoder dut (.clock(clock), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .busy(busy), .done(done), .unsupported(unsupported), .op_kind(op_kind),
        .word_op(word_op), .mem_operand(mem_operand), .reg_field(reg_field), .seg_field(seg_field),
        .mod_field(mod_field), .rm_field(rm_field), .imm_data(imm_data), .seq_active(seq_active),
        .seq_reg(seq_reg));
    sxdec_fetch_model fm (.clock(clock), .rst_n(rst_n), .byte_ready(byte_ready), .byte_valid(byte_valid),
        .byte_data(byte_data));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // queue bytes, lowest byte first
    task automatic send(input logic [31:0] bs, input int n);
        for (int i = 0; i < n; i++) fm.pending.push_back(bs[8*i +: 8]);
    endtask

    // run one form: time busy, check refusal while busy, walk of all-register forms, done pulse
    task automatic run_form(input logic [31:0] bs, input int n, input sxdec_op_e k, input int cyc,
                            input logic w, input logic m);
        int cnt;
        int t;
        cnt = 0;
        t = 0;
        send(bs, n);
        @(posedge clock);
        #2;
        while (!(busy === 1'b1) && t < 40) begin
            t++;
            @(posedge clock);
            #2;
        end
        while (busy === 1'b1 && cnt < 80) begin
            chk("byte_ready", 16'h0000, {15'h0000, byte_ready});
            if (k == SXD_PUSH_ALL || k == SXD_POP_ALL) begin
                chk("seq_active", {15'h0000, cnt < 8}, {15'h0000, seq_active});
                if (cnt < 8) chk("seq_reg", (k == SXD_PUSH_ALL) ? 16'(cnt) : 16'(7 - cnt), {13'h0000, seq_reg});
            end
            cnt++;
            @(posedge clock);
            #2;
        end
        chk("busy clocks", 16'(cyc), 16'(cnt));
        chk("done", 16'h0001, {15'h0000, done});
        chk("op_kind", {12'h000, k}, {12'h000, op_kind});
        chk("word_op", {15'h0000, w}, {15'h0000, word_op});
        chk("mem_operand", {15'h0000, m}, {15'h0000, mem_operand});
        @(posedge clock);
        #2;
    endtask

    // refused opcode or modrm: unsupported pulses, busy never rises
    task automatic expect_unsup(input logic [31:0] bs, input int n);
        logic seen;
        logic ran;
        seen = 1'b0;
        ran = 1'b0;
        send(bs, n);
        repeat (n + 6) begin
            @(posedge clock);
            #2;
            if (unsupported === 1'b1) seen = 1'b1;
            if (busy !== 1'b0) ran = 1'b1;
        end
        chk("unsupported", 16'h0001, {15'h0000, seen});
        chk("busy on refusal", 16'h0000, {15'h0000, ran});
    endtask

    task automatic test_push_mem();
        run_form(32'h1234_36FF, 4, SXD_PUSH_MEM, 16, 1'b1, 1'b1);
        chk("mod_field", 16'h0000, {14'h0000, mod_field});
        chk("rm_field", 16'h0006, {13'h0000, rm_field});
        expect_unsup(32'h0000_C0FF, 2);
    endtask

    task automatic test_gpr_forms();
        for (int r = 0; r < 8; r++) begin
            run_form({24'h0, 8'h50 + 8'(r)}, 1, SXD_PUSH_REG, 10, 1'b1, 1'b0);
            chk("reg_field", 16'(r), {13'h0000, reg_field});
            run_form({24'h0, 8'h58 + 8'(r)}, 1, SXD_POP_REG, 10, 1'b1, 1'b0);
            chk("reg_field", 16'(r), {13'h0000, reg_field});
            run_form({24'h0, 8'h90 + 8'(r)}, 1, SXD_EXCH_ACC, 3, 1'b1, 1'b0);
            chk("reg_field", 16'(r), {13'h0000, reg_field});
        end
    endtask

    task automatic test_seg_forms();
        for (int s = 0; s < 4; s++) begin
            run_form({24'h0, 3'h0, 2'(s), 3'h6}, 1, SXD_PUSH_SEG, 9, 1'b1, 1'b0);
            chk("seg_field", 16'(s), {14'h0000, seg_field});
            if (s != 1) begin
                run_form({24'h0, 3'h0, 2'(s), 3'h7}, 1, SXD_POP_SEG, 8, 1'b1, 1'b0);
                chk("seg_field", 16'(s), {14'h0000, seg_field});
            end
        end
        expect_unsup(32'h0000_000F, 1);
    endtask

    // word immediate with a slow fetch path, then negative and positive single bytes
    task automatic test_push_imm();
        fm.gap = 2;
        run_form(32'h0012_3468, 3, SXD_PUSH_IMM, 10, 1'b1, 1'b0);
        chk("imm_data", 16'h1234, imm_data);
        fm.gap = 0;
        run_form(32'h0000_806A, 2, SXD_PUSH_IMM, 10, 1'b1, 1'b0);
        chk("imm_data", 16'hFF80, imm_data);
        run_form(32'h0000_7F6A, 2, SXD_PUSH_IMM, 10, 1'b1, 1'b0);
        chk("imm_data", 16'h007F, imm_data);
    endtask

    task automatic test_all_regs();
        run_form(32'h0000_0060, 1, SXD_PUSH_ALL, 36, 1'b1, 1'b0);
        run_form(32'h0000_0061, 1, SXD_POP_ALL, 51, 1'b1, 1'b0);
    endtask

    task automatic test_pop_mem();
        run_form(32'h0010_468F, 3, SXD_POP_MEM, 20, 1'b1, 1'b1);
        chk("mod_field", 16'h0001, {14'h0000, mod_field});
        expect_unsup(32'h0000_088F, 2);
    endtask

    // word register exchange, and memory exchange in both widths
    task automatic test_exchange();
        run_form(32'h0000_C187, 2, SXD_EXCH_RM, 4, 1'b1, 1'b0);
        chk("reg_field", 16'h0000, {13'h0000, reg_field});
        run_form(32'h1234_0686, 4, SXD_EXCH_RM, 17, 1'b0, 1'b1);
        run_form(32'h0000_0787, 2, SXD_EXCH_RM, 17, 1'b1, 1'b1);
        chk("rm_field", 16'h0007, {13'h0000, rm_field});
        run_form(32'h3412_8787, 4, SXD_EXCH_RM, 17, 1'b1, 1'b1);
        chk("mod_field", 16'h0002, {14'h0000, mod_field});
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clock);
        test_push_mem();
        test_gpr_forms();
        test_seg_forms();
        test_push_imm();
        test_all_regs();
        test_pop_mem();
        test_exchange();
        conclude();
    end
endmodule // tb_top
